// ===== smpx_board.sv
// Board model that drives the shared pins whenever the device lets go.
`timescale 1ns/100ps
module smpx_board (
    input wire smpx_pkg::smpx_pins_t pin_out,
    input wire smpx_pkg::smpx_pins_t pin_oe,
    input wire logic [23:0] board_val,
    output smpx_pkg::smpx_pins_t pin_in
);
    import smpx_pkg::*;
    // A released pin shows the board's own source, never a stale value.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_val);
endmodule

// ===== smpx_consts.svh
// Register addresses, field positions, masks and reset values of the pin mux.
`ifndef SMPX_CONSTS_SVH
`define SMPX_CONSTS_SVH

`define SMPX_ADDR_MUX_A 16'h7090
`define SMPX_ADDR_MUX_B 16'h7092
`define SMPX_ADDR_PORT_A 16'h7098
`define SMPX_ADDR_PORT_B 16'h709A
`define SMPX_ADDR_PORT_C 16'h709C

`define SMPX_DATA_LSB 0
`define SMPX_DIR_LSB 8

`define SMPX_MUX_A_MASK 16'hFF0F
`define SMPX_MUX_B_MASK 16'h00FD
`define SMPX_PORT_A_MASK 16'h0F0F
`define SMPX_PORT_FULL_MASK 16'hFFFF

`define SMPX_MUX_A_RESET 16'h0000
`define SMPX_MUX_B_RESET 16'h0000
`define SMPX_PORT_RESET 16'h0000

`define SMPX_PIN_C1 17
`define SMPX_PIN_C2 18
`define SMPX_PIN_C3 19

`endif

// ===== smpx_pin_cell.sv
// One shared pin: chooses between the peripheral and the port I/O bits.
`timescale 1ns/100ps
module smpx_pin_cell (
    input wire logic primary_sel,
    input wire logic io_dir,
    input wire logic io_data,
    input wire logic periph_out,
    input wire logic periph_oe,
    output logic pin_out,
    output logic pin_oe
);
    // Direction and data are ignored while the peripheral owns the pin.
    assign pin_out = primary_sel ? periph_out : io_data;
    assign pin_oe = primary_sel ? periph_oe : io_dir;
endmodule

// ===== smpx_pkg.sv
// Types shared by the shared-pin mux and port logic.
package smpx_pkg;

    typedef struct packed {
        logic [7:0] port_c;
        logic [7:0] port_b;
        logic [7:0] port_a;
    } smpx_pins_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } smpx_cpu_req_t;

    typedef enum logic [1:0] {
        SMPX_CLK_IO = 2'b00,
        SMPX_CLK_WD = 2'b01,
        SMPX_CLK_SYS = 2'b10,
        SMPX_CLK_CPU = 2'b11
    } smpx_clk_sel_t;

    typedef struct packed {
        logic [15:0] mux_a;
        logic [15:0] mux_b;
        logic [15:0] port_a;
        logic [15:0] port_b;
        logic [15:0] port_c;
        logic [15:0] rdata;
        logic rvalid;
    } smpx_state_t;

endpackage

// ===== smpx_sync.sv
// Three-stage pin synchroniser with a settle filter on the last two stages.
`timescale 1ns/100ps
module smpx_sync #(
    parameter int WIDTH = 24
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] filt;
    } smpx_sync_state_t;

    smpx_sync_state_t s_q;
    smpx_sync_state_t s_d;
    logic [WIDTH-1:0] agree;

    // Only the second stage looks at the first; a level counts once the
    // second and third stages agree, so a single metastable sample is held.
    always_comb begin
        agree = ~(s_q.s2 ^ s_q.s3);
        s_d.s1 = async_in;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        s_d.filt = (agree & s_q.s3) | (~agree & s_q.filt);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.filt;
endmodule

// ===== smpx_top.sv
// Shared-pin mux and general-purpose I/O ports A, B and C.
`timescale 1ns/100ps
`include "smpx_consts.svh"
module smpx_top (
    input wire logic core_clk,
    input wire logic reset,
    input wire smpx_pkg::smpx_cpu_req_t cpu_req,
    output logic cpu_hit,
    output logic [15:0] cpu_rdata,
    output logic cpu_rvalid,
    input wire smpx_pkg::smpx_clk_sel_t clock_output_select,
    input wire logic watchdog_clock,
    input wire logic system_clock_signal,
    input wire logic cpu_clock_signal,
    input wire smpx_pkg::smpx_pins_t periph_out,
    input wire smpx_pkg::smpx_pins_t periph_oe,
    output smpx_pkg::smpx_pins_t periph_in,
    input wire smpx_pkg::smpx_pins_t pin_in,
    output smpx_pkg::smpx_pins_t pin_out,
    output smpx_pkg::smpx_pins_t pin_oe
);
    import smpx_pkg::*;

    localparam smpx_state_t RESET_STATE = '{
        mux_a: `SMPX_MUX_A_RESET,
        mux_b: `SMPX_MUX_B_RESET,
        port_a: `SMPX_PORT_RESET,
        port_b: `SMPX_PORT_RESET,
        port_c: `SMPX_PORT_RESET,
        rdata: 16'h0000,
        rvalid: 1'b0
    };

    smpx_state_t s_q;
    smpx_state_t s_d;
    logic [23:0] level;
    logic [23:0] dir_vec;
    logic [23:0] data_vec;
    logic [23:0] prim_sel;
    logic [23:0] eff_out;
    logic [23:0] eff_oe;
    logic [23:0] pout;
    logic [23:0] poe;
    logic sel_mux_a;
    logic sel_mux_b;
    logic sel_port_a;
    logic sel_port_b;
    logic sel_port_c;

    smpx_sync #(
        .WIDTH(24)
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(pin_in),
        .sync_out(level)
    );

    // Peripherals see the same clean level that the port registers read.
    assign periph_in = level;

    assign sel_mux_a = (cpu_req.addr == `SMPX_ADDR_MUX_A);
    assign sel_mux_b = (cpu_req.addr == `SMPX_ADDR_MUX_B);
    assign sel_port_a = (cpu_req.addr == `SMPX_ADDR_PORT_A);
    assign sel_port_b = (cpu_req.addr == `SMPX_ADDR_PORT_B);
    assign sel_port_c = (cpu_req.addr == `SMPX_ADDR_PORT_C);
    assign cpu_hit = sel_mux_a | sel_mux_b | sel_port_a | sel_port_b
        | sel_port_c;

    // Output pins read back the written bit, input pins the pin level.
    function automatic logic [15:0] port_view(
        input logic [15:0] reg_v,
        input logic [7:0] lvl
    );
        logic [7:0] dir;
        logic [7:0] dat;
        dir = reg_v[`SMPX_DIR_LSB +: 8];
        dat = reg_v[`SMPX_DATA_LSB +: 8];
        return {dir, (dir & dat) | (~dir & lvl)};
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        if (cpu_req.wr) begin
            // Bits with no pin behind them are masked and read as zero.
            if (sel_mux_a) begin
                s_d.mux_a = cpu_req.wdata & `SMPX_MUX_A_MASK;
            end
            if (sel_mux_b) begin
                s_d.mux_b = cpu_req.wdata & `SMPX_MUX_B_MASK;
            end
            if (sel_port_a) begin
                s_d.port_a = cpu_req.wdata & `SMPX_PORT_A_MASK;
            end
            if (sel_port_b) begin
                s_d.port_b = cpu_req.wdata & `SMPX_PORT_FULL_MASK;
            end
            if (sel_port_c) begin
                s_d.port_c = cpu_req.wdata & `SMPX_PORT_FULL_MASK;
            end
        end
        if (cpu_req.rd && cpu_hit) begin
            s_d.rvalid = 1'b1;
            if (sel_mux_a) begin
                s_d.rdata = s_q.mux_a;
            end else if (sel_mux_b) begin
                s_d.rdata = s_q.mux_b;
            end else if (sel_port_a) begin
                s_d.rdata = port_view(s_q.port_a, level[7:0])
                    & `SMPX_PORT_A_MASK;
            end else if (sel_port_b) begin
                s_d.rdata = port_view(s_q.port_b, level[15:8]);
            end else begin
                s_d.rdata = port_view(s_q.port_c, level[23:16]);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign cpu_rdata = s_q.rdata;
    assign cpu_rvalid = s_q.rvalid;

    assign dir_vec = {s_q.port_c[`SMPX_DIR_LSB +: 8],
        s_q.port_b[`SMPX_DIR_LSB +: 8], s_q.port_a[`SMPX_DIR_LSB +: 8]};
    assign data_vec = {s_q.port_c[`SMPX_DATA_LSB +: 8],
        s_q.port_b[`SMPX_DATA_LSB +: 8], s_q.port_a[`SMPX_DATA_LSB +: 8]};

    // Pin C1 has no mux bit; the clock select field decides it instead.
    // The clock sources pass combinationally since they run at core rate.
    always_comb begin
        eff_out = periph_out;
        eff_oe = periph_oe;
        prim_sel = {s_q.mux_b[7:4], ~s_q.mux_b[3:2], 1'b0, s_q.mux_b[0],
            s_q.mux_a[15:8], s_q.mux_a[7:0]};
        case (clock_output_select)
            SMPX_CLK_IO: begin
                prim_sel[`SMPX_PIN_C1] = 1'b0;
            end
            SMPX_CLK_WD: begin
                prim_sel[`SMPX_PIN_C1] = 1'b1;
                eff_out[`SMPX_PIN_C1] = watchdog_clock;
                eff_oe[`SMPX_PIN_C1] = 1'b1;
            end
            SMPX_CLK_SYS: begin
                prim_sel[`SMPX_PIN_C1] = 1'b1;
                eff_out[`SMPX_PIN_C1] = system_clock_signal;
                eff_oe[`SMPX_PIN_C1] = 1'b1;
            end
            SMPX_CLK_CPU: begin
                prim_sel[`SMPX_PIN_C1] = 1'b1;
                eff_out[`SMPX_PIN_C1] = cpu_clock_signal;
                eff_oe[`SMPX_PIN_C1] = 1'b1;
            end
            default: begin
                prim_sel[`SMPX_PIN_C1] = 1'b0;
            end
        endcase
    end

    // Only the 24 group-one pins are built; pins with self-contained I/O
    // stay inside their own peripherals.
    for (genvar i = 0; i < 24; i++) begin : g_pin
        smpx_pin_cell u_cell (
            .primary_sel(prim_sel[i]),
            .io_dir(dir_vec[i]),
            .io_data(data_vec[i]),
            .periph_out(eff_out[i]),
            .periph_oe(eff_oe[i]),
            .pin_out(pout[i]),
            .pin_oe(poe[i])
        );
    end

    assign pin_out = pout;
    assign pin_oe = poe;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    primary_route_a: assert property (
        ((pout ^ eff_out) & prim_sel) == 24'h000000
    ) else $error("Primary pin does not follow its peripheral.");

    io_direction_a: assert property (
        ((poe ^ dir_vec) & ~prim_sel) == 24'h000000
    ) else $error("Port pin enable differs from its direction bit.");

    io_drive_a: assert property (
        ((pout ^ data_vec) & ~prim_sel & dir_vec) == 24'h000000
    ) else $error("Port output pin does not carry its data bit.");

    input_read_a: assert property (
        (cpu_req.rd && sel_port_b && !s_q.port_b[8])
        |=> cpu_rvalid && (cpu_rdata[0] == $past(level[8]))
    ) else $error("Input pin read does not return its level.");

    port_write_a: assert property (
        (cpu_req.wr && sel_port_a)
        |=> s_q.port_a == ($past(cpu_req.wdata) & `SMPX_PORT_A_MASK)
    ) else $error("Port A register did not take the write.");

    mux_b_reserved_a: assert property (
        (cpu_req.rd && sel_mux_b) |=> cpu_rdata[15:8] == 8'h00
    ) else $error("Unused control B bits read nonzero.");

    inverted_select_a: assert property (
        s_q.mux_b[2] |-> (poe[`SMPX_PIN_C2] == dir_vec[`SMPX_PIN_C2])
    ) else $error("Pin C2 not in port mode with select bit set.");

    clock_out_a: assert property (
        (clock_output_select == SMPX_CLK_SYS)
        |-> poe[`SMPX_PIN_C1] && (pout[`SMPX_PIN_C1] == system_clock_signal)
    ) else $error("Clock pin does not carry the system clock.");

    sync_settle_a: assert property (
        (pin_in[8] == $past(pin_in[8]))[*5] |-> level[8] == pin_in[8]
    ) else $error("Synchronised level did not settle in four cycles.");

    unmapped_idle_a: assert property (
        (cpu_req.rd && !cpu_hit) |=> !cpu_rvalid
    ) else $error("Read of a foreign address was answered.");

    foreign_write_a: assert property (
        (cpu_req.wr && !cpu_hit)
        |=> $stable({s_q.mux_a, s_q.mux_b, s_q.port_a, s_q.port_b,
            s_q.port_c})
    ) else $error("Write to a foreign address changed a register.");

    // Every clock code is checked, so a swapped source cannot hide
    // behind the one code that a short test happens to use.
    wd_clock_out_a: assert property (
        (clock_output_select == SMPX_CLK_WD)
        |-> poe[`SMPX_PIN_C1] && (pout[`SMPX_PIN_C1] == watchdog_clock)
    ) else $error("Clock pin does not carry the watchdog clock.");

    cpu_clock_out_a: assert property (
        (clock_output_select == SMPX_CLK_CPU)
        |-> poe[`SMPX_PIN_C1] && (pout[`SMPX_PIN_C1] == cpu_clock_signal)
    ) else $error("Clock pin does not carry the CPU clock.");

    clock_pin_io_a: assert property (
        (clock_output_select == SMPX_CLK_IO)
        |-> (poe[`SMPX_PIN_C1] == dir_vec[`SMPX_PIN_C1])
            && (pout[`SMPX_PIN_C1] == data_vec[`SMPX_PIN_C1])
    ) else $error("Clock pin in port mode does not follow its bits.");

    inverted_c3_a: assert property (
        !s_q.mux_b[3] |-> (poe[`SMPX_PIN_C3] == periph_oe[`SMPX_PIN_C3])
            && (pout[`SMPX_PIN_C3] == periph_out[`SMPX_PIN_C3])
    ) else $error("Pin C3 not handed to its peripheral with select clear.");

    io_isolated_a: assert property (
        ((poe ^ eff_oe) & prim_sel) == 24'h000000
    ) else $error("Port bits leak onto a primary pin enable.");

    mux_a_write_a: assert property (
        (cpu_req.wr && sel_mux_a)
        |=> s_q.mux_a == ($past(cpu_req.wdata) & `SMPX_MUX_A_MASK)
    ) else $error("Control A register did not take the write.");

    mux_a_reserved_a: assert property (
        (cpu_req.rd && sel_mux_a) |=> (cpu_rdata & ~`SMPX_MUX_A_MASK) == 0
    ) else $error("Unused control A bits read nonzero.");

    dir_readback_a: assert property (
        (cpu_req.rd && sel_port_c)
        |=> cpu_rdata[`SMPX_DIR_LSB +: 8] == $past(dir_vec[23:16])
    ) else $error("Port C direction bits do not read back.");

    output_read_a: assert property (
        (cpu_req.rd && sel_port_c && s_q.port_c[`SMPX_DIR_LSB])
        |=> cpu_rdata[`SMPX_DATA_LSB] == $past(data_vec[16])
    ) else $error("Output pin read does not return its written bit.");

    cover_port_c_write: cover property (cpu_req.wr && sel_port_c);
    cover_cpu_clock: cover property (
        clock_output_select == SMPX_CLK_CPU && poe[`SMPX_PIN_C1]);
    cover_input_read: cover property (
        cpu_req.rd && sel_port_b ##1 cpu_rvalid);
    cover_foreign_write: cover property (cpu_req.wr && !cpu_hit);
    cover_inverted_io: cover property (
        s_q.mux_b[2] && s_q.mux_b[3] && poe[`SMPX_PIN_C2]);
endmodule

// ===== smpx_top_bench.sv
// Self-checking bench for the shared-pin mux and I/O ports.
`timescale 1ns/100ps
`include "smpx_consts.svh"
module smpx_top_bench;
    import smpx_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    smpx_cpu_req_t cpu_req = '0;
    logic cpu_hit;
    logic cpu_rvalid;
    logic [15:0] cpu_rdata;
    smpx_clk_sel_t clk_sel = SMPX_CLK_IO;
    logic [2:0] clks = 3'h0;
    logic [23:0] board_val = 24'h000000;
    smpx_pins_t periph_out = '0;
    smpx_pins_t periph_oe = '0;
    smpx_pins_t periph_in, pin_in, pin_out, pin_oe;
    logic [23:0] e_out, e_oe, lvl;
    logic [15:0] m_a, m_b, rnd;
    logic [15:0] p [3];
    logic [15:0] exp_q [$];
    logic [15:0] addrs [5] = '{`SMPX_ADDR_MUX_A, `SMPX_ADDR_MUX_B,
        `SMPX_ADDR_PORT_A, `SMPX_ADDR_PORT_B, `SMPX_ADDR_PORT_C};
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;

    smpx_top dut (.core_clk(core_clk), .reset(reset), .cpu_req(cpu_req),
        .cpu_hit(cpu_hit), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
        .clock_output_select(clk_sel), .watchdog_clock(clks[0]),
        .system_clock_signal(clks[1]), .cpu_clock_signal(clks[2]),
        .periph_out(periph_out), .periph_oe(periph_oe),
        .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));
    smpx_board board (.pin_out(pin_out), .pin_oe(pin_oe),
        .board_val(board_val), .pin_in(pin_in));

    always #2.5 core_clk = ~core_clk;

    task automatic fail(input string msg);
        n_fail++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic final_report();
        $display("Counts: %0d compared, %0d mismatched", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail("timeout");
            final_report();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic draw();
        rnd = lfsr(rnd);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge core_clk);
        cpu_req.wr = 1'b1;
        cpu_req.addr = a;
        cpu_req.wdata = d;
        @(negedge core_clk);
        cpu_req.wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic hit,
                      input logic [15:0] e);
        @(negedge core_clk);
        cpu_req.rd = 1'b1;
        cpu_req.addr = a;
        if (hit) exp_q.push_back(e);
        #1;
        checked++;
        if (cpu_hit !== hit) fail("address decode");
        @(negedge core_clk);
        cpu_req.rd = 1'b0;
    endtask

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] e);
        checked++;
        if (got !== e) fail($sformatf("read %h expected %h", got, e));
    endtask

    // Read answers are matched in order against the notes made by rd.
    always @(negedge core_clk) begin
        if (!reset && cpu_rvalid !== 1'b0) begin
            if (exp_q.size() == 0) fail("unexpected read answer");
            else cmp_word(cpu_rdata, exp_q.pop_front());
        end
    end

    // Expected pin drive and pin level from the mirrored registers.
    task automatic calc();
        logic sel;
        for (int i = 0; i < 24; i++) begin
            sel = (i < 8) ? (i < 4 && m_a[i]) : (i < 16) ? m_a[i] : m_b[i-16];
            if (i == `SMPX_PIN_C2 || i == `SMPX_PIN_C3) sel = !sel;
            e_out[i] = sel ? periph_out[i] : p[i/8][i%8];
            e_oe[i] = sel ? periph_oe[i] : p[i/8][i%8+8];
            if (i == `SMPX_PIN_C1 && clk_sel != SMPX_CLK_IO) begin
                e_out[i] = clks[clk_sel-1];
                e_oe[i] = 1'b1;
            end
        end
        lvl = (e_oe & e_out) | (~e_oe & board_val);
    endtask

    task automatic check_pins();
        calc();
        checked++;
        if (pin_oe !== e_oe) fail("pin enables");
        if ((pin_out & e_oe) !== (e_out & e_oe)) fail("pin drive");
        if (periph_in !== lvl) fail("synchronised levels");
    endtask

    task automatic read_all();
        logic [15:0] e;
        rd(addrs[0], 1'b1, m_a);
        rd(addrs[1], 1'b1, m_b);
        for (int k = 0; k < 3; k++) begin
            e = {p[k][15:8], (p[k][7:0] & p[k][15:8]) |
                 (lvl[k*8+:8] & ~p[k][15:8])};
            // Port A bits 4 to 7 are cleared by the port A mask and read zero.
            if (k == 0) e = e & `SMPX_PORT_A_MASK;
            rd(addrs[k+2], 1'b1, e);
        end
        rd(16'h7094, 1'b0, 16'h0000);
    endtask

    initial begin
        rnd = 16'hCE7D;
        m_a = 16'h0000;
        m_b = 16'h0000;
        p = '{16'h0000, 16'h0000, 16'h0000};
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        repeat (6) @(negedge core_clk);
        check_pins();
        read_all();
        $display("test reset values done");
        for (int it = 0; it < 48; it++) begin
            draw();
            m_a = rnd & `SMPX_MUX_A_MASK;
            draw();
            m_b = rnd & `SMPX_MUX_B_MASK;
            for (int k = 0; k < 3; k++) begin
                draw();
                p[k] = rnd & ((k == 0) ? `SMPX_PORT_A_MASK : 16'hFFFF);
            end
            wr(addrs[0], m_a | 16'h00F0);
            wr(addrs[1], m_b | 16'hFF02);
            wr(addrs[2], p[0] | 16'hF0F0);
            wr(addrs[3], p[1]);
            wr(addrs[4], p[2]);
            wr(16'h7096, 16'hFFFF);
            @(negedge core_clk);
            draw();
            periph_out = {rnd[7:0], rnd};
            draw();
            periph_oe = {rnd[15:8], rnd};
            draw();
            board_val = {rnd, rnd[15:8]};
            clk_sel = smpx_clk_sel_t'(it % 4);
            clks = rnd[2:0];
            repeat (6) @(negedge core_clk);
            check_pins();
            read_all();
        end
        $display("test random mux and port traffic done");
        repeat (3) @(negedge core_clk);
        if (exp_q.size() != 0) fail("missing read answers");
        final_report();
    end
endmodule
